/* design/rx_mux_consts.vh */
// Constants for the receive multifunction pin multiplexer
`ifndef RX_MUX_CONSTS_VH
`define RX_MUX_CONSTS_VH

// Register byte offsets
`define OFS_PIN_CFG_A        8'h00
`define OFS_PIN_CFG_B        8'h04
`define OFS_PIN_CFG_C        8'h08
`define OFS_DIG_IF_CTRL3     8'h0C
`define OFS_OUT_DATA_PUSH    8'h10
`define OFS_PIN_STATUS       8'h14

// Field layout
`define FUNC_W               4
`define NUM_PORTS            3
`define NUM_PINS             9
`define BIT_RX_EDGE_SELECT   0
`define BIT_STAT_EMPTY       9
`define BIT_STAT_FULL        10
`define BIT_STAT_CONFLICT    11

// Pin function encodings, bit 3 marks an output function
`define FN_IN_IDLE           4'h0
`define FN_IN_DATA           4'h1
`define FN_IN_MARKER         4'h2
`define FN_OUT_DATA          4'h8
`define FN_OUT_LOW           4'h9
`define FN_OUT_HIGH          4'hA
`define FN_DIR_BIT           3

// Reset values
`define RST_FUNC             4'h0
`define RST_CTRL3            1'b0
`define RST_WORD             32'h0000_0000

// Bus responses
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

// Output data buffer
`define FIFO_DEPTH           16
`define FIFO_AW              4

`endif

/* design/rx_mux_fifo.v */
// Output data FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module rx_mux_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_in,
    input  wire             arst_n_in,
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out,
    output wire             full_out,
    output wire             empty_out
);
    localparam [AW:0] DEPTH_CNT = DEPTH;
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;
    wire            push;
    wire            pop;

    // Handshakes and flags
    assign full_out      = (count_q == DEPTH_CNT);
    assign empty_out     = (count_q == {(AW+1){1'b0}});
    assign in_ready_out  = !full_out;
    assign out_valid_out = !empty_out;
    assign out_data_out  = mem_q[rd_ptr_q];
    assign push          = in_valid_in && !full_out;
    assign pop           = out_ready_in && !empty_out;

    // Storage array
    always @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    // Pointers and fill count
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_q <= count_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_q <= count_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

/* design/rx_pin_cell.v */
// One receive multifunction pin: direction decode, capture and launch
`timescale 1ns/100ps
`default_nettype none
`include "rx_mux_consts.vh"
module rx_pin_cell (
    input  wire                clk_in,
    input  wire                arst_n_in,
    input  wire [`FUNC_W-1:0]  func_in,
    input  wire                edge_in,
    input  wire                pin_sync_in,
    input  wire                out_bit_in,
    output reg                 pin_out,
    output reg                 pin_oe_out,
    output reg                 capture_out
);
    wire is_output;

    // Direction follows the selected function
    assign is_output = func_in[`FN_DIR_BIT];

    // Reset leaves the pin as an input
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_oe_out  <= 1'b0;
            pin_out     <= 1'b0;
            capture_out <= 1'b0;
        end else begin
            pin_oe_out <= is_output;
            if (edge_in) begin
                // Launch or capture on the chosen framer clock edge
                if (func_in == `FN_OUT_DATA) begin
                    pin_out <= out_bit_in;
                end else begin
                    pin_out <= (func_in == `FN_OUT_HIGH);
                end
                if (!is_output && (func_in != `FN_IN_IDLE)) begin
                    capture_out <= pin_sync_in;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* design/receive_multifunction_port_mux.v */
// Receive multifunction pin multiplexer for ports 5 to 7 with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
`include "rx_mux_consts.vh"
module receive_multifunction_port_mux (
    input  wire                  clk_in,
    input  wire                  arst_n_in,
    // AXI4-Lite slave
    input  wire [7:0]            s_axi_awaddr_in,
    input  wire                  s_axi_awvalid_in,
    output wire                  s_axi_awready_out,
    input  wire [31:0]           s_axi_wdata_in,
    input  wire [3:0]            s_axi_wstrb_in,
    input  wire                  s_axi_wvalid_in,
    output wire                  s_axi_wready_out,
    output reg  [1:0]            s_axi_bresp_out,
    output reg                   s_axi_bvalid_out,
    input  wire                  s_axi_bready_in,
    input  wire [7:0]            s_axi_araddr_in,
    input  wire                  s_axi_arvalid_in,
    output wire                  s_axi_arready_out,
    output reg  [31:0]           s_axi_rdata_out,
    output reg  [1:0]            s_axi_rresp_out,
    output reg                   s_axi_rvalid_out,
    input  wire                  s_axi_rready_in,
    // Framer receive clock, sampled as a plain input
    input  wire                  framer_rx_clock_in,
    // Pins, index = 3 * (port - 5) + letter (A=0, B=1, C=2)
    input  wire [`NUM_PINS-1:0]  rx_multi_pin_in,
    output wire [`NUM_PINS-1:0]  rx_multi_pin_out,
    output wire [`NUM_PINS-1:0]  rx_multi_pin_oe_out
);
    // Function select per pin, one field for every pin
    reg  [`FUNC_W-1:0]   rx_pin_function_select_q [0:`NUM_PINS-1];
    reg                  rx_edge_select_q;
    // Bus state
    reg                  aw_full_q;
    reg  [7:0]           awaddr_q;
    reg                  w_full_q;
    reg  [31:0]          wdata_q;
    reg  [3:0]           wstrb_q;
    // Synchronisers
    reg  [`NUM_PINS-1:0] pin_meta_q;
    reg  [`NUM_PINS-1:0] pin_sync_q;
    reg                  fclk_meta_q;
    reg                  fclk_sync_q;
    reg                  fclk_prev_q;
    // Derived
    wire                 rise_edge;
    wire                 fall_edge;
    wire                 active_edge;
    wire [`NUM_PINS-1:0] capture;
    wire [`NUM_PINS-1:0] out_is_data;
    wire                 any_out_data;
    wire                 fifo_in_ready;
    wire                 fifo_out_valid;
    wire [`NUM_PINS-1:0] fifo_out_data;
    wire                 fifo_full;
    wire                 fifo_empty;
    wire                 fifo_pop;
    wire                 wr_is_push;
    wire                 wr_commit;
    wire                 fifo_push;
    reg                  conflict;
    reg  [31:0]          rd_word;
    reg                  rd_hit;
    reg                  wr_hit;
    integer              i;
    integer              j;
    integer              k;

    // Pin and framer clock synchronisers
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_meta_q  <= {`NUM_PINS{1'b1}};
            pin_sync_q  <= {`NUM_PINS{1'b1}};
            fclk_meta_q <= 1'b0;
            fclk_sync_q <= 1'b0;
            fclk_prev_q <= 1'b0;
        end else begin
            pin_meta_q  <= rx_multi_pin_in;
            pin_sync_q  <= pin_meta_q;
            fclk_meta_q <= framer_rx_clock_in;
            fclk_sync_q <= fclk_meta_q;
            fclk_prev_q <= fclk_sync_q;
        end
    end

    // Edge detection and edge choice
    assign rise_edge   = fclk_sync_q && !fclk_prev_q;
    assign fall_edge   = !fclk_sync_q && fclk_prev_q;
    assign active_edge = rx_edge_select_q ? rise_edge : fall_edge;

    // One cell per pin, each with its own function field
    genvar g;
    generate
        for (g = 0; g < `NUM_PINS; g = g + 1) begin : pin_gen
            assign out_is_data[g] = (rx_pin_function_select_q[g] == `FN_OUT_DATA);
            rx_pin_cell u_cell (
                .clk_in      (clk_in),
                .arst_n_in   (arst_n_in),
                .func_in     (rx_pin_function_select_q[g]),
                .edge_in     (active_edge),
                .pin_sync_in (pin_sync_q[g]),
                .out_bit_in  (fifo_out_valid & fifo_out_data[g]),
                .pin_out     (rx_multi_pin_out[g]),
                .pin_oe_out  (rx_multi_pin_oe_out[g]),
                .capture_out (capture[g])
            );
        end
    endgenerate

    // Output data drains one word per active edge while a pin uses it
    assign any_out_data = |out_is_data;
    assign fifo_pop     = active_edge && any_out_data;

    rx_mux_fifo #(
        .WIDTH (`NUM_PINS),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .clk_in        (clk_in),
        .arst_n_in     (arst_n_in),
        .in_valid_in   (fifo_push),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (wdata_q[`NUM_PINS-1:0]),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_out_data),
        .full_out      (fifo_full),
        .empty_out     (fifo_empty)
    );

    // Flag two pins sharing one input function
    always @* begin
        conflict = 1'b0;
        for (k = 0; k < `NUM_PINS; k = k + 1) begin
            for (j = k + 1; j < `NUM_PINS; j = j + 1) begin
                if ((rx_pin_function_select_q[k] == rx_pin_function_select_q[j]) &&
                    !rx_pin_function_select_q[k][`FN_DIR_BIT] &&
                    (rx_pin_function_select_q[k] != `FN_IN_IDLE)) begin
                    conflict = 1'b1;
                end
            end
        end
    end

    // Write channel handshakes; a push waits while the buffer is full
    assign s_axi_awready_out = !aw_full_q;
    assign s_axi_wready_out  = !w_full_q;
    assign wr_is_push        = (awaddr_q == `OFS_OUT_DATA_PUSH);
    assign wr_commit         = aw_full_q && w_full_q && !s_axi_bvalid_out &&
                               (!wr_is_push || fifo_in_ready);
    assign fifo_push         = wr_commit && wr_is_push && wstrb_q[0];

    // Write address decode
    always @* begin
        case (awaddr_q)
            `OFS_PIN_CFG_A:     wr_hit = 1'b1;
            `OFS_PIN_CFG_B:     wr_hit = 1'b1;
            `OFS_PIN_CFG_C:     wr_hit = 1'b1;
            `OFS_DIG_IF_CTRL3:  wr_hit = 1'b1;
            `OFS_OUT_DATA_PUSH: wr_hit = 1'b1;
            `OFS_PIN_STATUS:    wr_hit = 1'b1;
            default:            wr_hit = 1'b0;
        endcase
    end

    // Write path and configuration registers
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            aw_full_q        <= 1'b0;
            awaddr_q         <= 8'h00;
            w_full_q         <= 1'b0;
            wdata_q          <= `RST_WORD;
            wstrb_q          <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= `RESP_OKAY;
            rx_edge_select_q <= `RST_CTRL3;
            for (i = 0; i < `NUM_PINS; i = i + 1) begin
                rx_pin_function_select_q[i] <= `RST_FUNC;
            end
        end else begin
            if (s_axi_awvalid_in && !aw_full_q) begin
                aw_full_q <= 1'b1;
                awaddr_q  <= {s_axi_awaddr_in[7:2], 2'b00};
            end
            if (s_axi_wvalid_in && !w_full_q) begin
                w_full_q <= 1'b1;
                wdata_q  <= s_axi_wdata_in;
                wstrb_q  <= s_axi_wstrb_in;
            end
            if (wr_commit) begin
                aw_full_q        <= 1'b0;
                w_full_q         <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                // Letter register holds one field per port
                for (i = 0; i < `NUM_PORTS; i = i + 1) begin
                    if (awaddr_q == `OFS_PIN_CFG_A && wstrb_q[i/2]) begin
                        rx_pin_function_select_q[3*i] <= wdata_q[4*i +: 4];
                    end
                    if (awaddr_q == `OFS_PIN_CFG_B && wstrb_q[i/2]) begin
                        rx_pin_function_select_q[3*i+1] <= wdata_q[4*i +: 4];
                    end
                    if (awaddr_q == `OFS_PIN_CFG_C && wstrb_q[i/2]) begin
                        rx_pin_function_select_q[3*i+2] <= wdata_q[4*i +: 4];
                    end
                end
                if (awaddr_q == `OFS_DIG_IF_CTRL3 && wstrb_q[0]) begin
                    rx_edge_select_q <= wdata_q[`BIT_RX_EDGE_SELECT];
                end
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    // Read data mux
    always @* begin
        rd_word = `RST_WORD;
        rd_hit  = 1'b1;
        case ({s_axi_araddr_in[7:2], 2'b00})
            `OFS_PIN_CFG_A: begin
                rd_word[11:0] = {rx_pin_function_select_q[6], rx_pin_function_select_q[3],
                                 rx_pin_function_select_q[0]};
            end
            `OFS_PIN_CFG_B: begin
                rd_word[11:0] = {rx_pin_function_select_q[7], rx_pin_function_select_q[4],
                                 rx_pin_function_select_q[1]};
            end
            `OFS_PIN_CFG_C: begin
                rd_word[11:0] = {rx_pin_function_select_q[8], rx_pin_function_select_q[5],
                                 rx_pin_function_select_q[2]};
            end
            `OFS_DIG_IF_CTRL3: begin
                rd_word[`BIT_RX_EDGE_SELECT] = rx_edge_select_q;
            end
            `OFS_OUT_DATA_PUSH: begin
                rd_word = `RST_WORD;
            end
            `OFS_PIN_STATUS: begin
                rd_word[`NUM_PINS-1:0]     = capture;
                rd_word[`BIT_STAT_EMPTY]    = fifo_empty;
                rd_word[`BIT_STAT_FULL]     = fifo_full;
                rd_word[`BIT_STAT_CONFLICT] = conflict;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel
    assign s_axi_arready_out = !s_axi_rvalid_out;

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= `RST_WORD;
            s_axi_rresp_out  <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out  <= rd_word;
                s_axi_rresp_out  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* design/_unused_guard.v */
`timescale 1ns/100ps

/* tb/rx_mux_chk.sv */
// Port checker for the receive multifunction pin multiplexer
`timescale 1ns/100ps
`default_nettype none
`include "rx_mux_consts.vh"
module rx_mux_chk (
    input wire logic                 clk_in,
    input wire logic                 arst_n_in,
    input wire logic [7:0]           s_axi_awaddr_in,
    input wire logic                 s_axi_awvalid_in,
    input wire logic                 s_axi_awready_out,
    input wire logic [31:0]          s_axi_wdata_in,
    input wire logic [3:0]           s_axi_wstrb_in,
    input wire logic                 s_axi_wvalid_in,
    input wire logic                 s_axi_wready_out,
    input wire logic                 s_axi_bvalid_out,
    input wire logic                 s_axi_bready_in,
    input wire logic                 s_axi_arvalid_in,
    input wire logic                 s_axi_arready_out,
    input wire logic                 s_axi_rvalid_out,
    input wire logic                 framer_rx_clock_in,
    input wire logic [`NUM_PINS-1:0] rx_multi_pin_out,
    input wire logic [`NUM_PINS-1:0] rx_multi_pin_oe_out
);
    logic [7:0]  aw_q;
    logic [31:0] wd_q;
    logic [3:0]  ws_q;
    logic [11:0] cfg_q [0:2];
    logic        esel_q, busy_q, bv_q;
    logic [2:0]  fs_q;
    logic [3:0]  since_q;
    logic [8:0]  exp_oe, hi_m, lo_m;
    logic [3:0]  fn;
    wire         det = esel_q ? (fs_q[1] & ~fs_q[2]) : (~fs_q[1] & fs_q[2]);

    // Expected direction and fixed levels from shadow config
    always @* begin
        for (int p = 0; p < 9; p++) begin
            fn = cfg_q[p % 3][4 * (p / 3) +: 4];
            exp_oe[p] = fn[`FN_DIR_BIT];
            hi_m[p] = (fn == `FN_OUT_HIGH);
            lo_m[p] = (fn == `FN_OUT_LOW);
        end
    end

    // Shadow of config writes, framer edge finder, cycles since edge
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            aw_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            cfg_q <= '{default: 12'h000};
            esel_q <= 1'b0;
            busy_q <= 1'b0;
            bv_q <= 1'b0;
            fs_q <= 3'h0;
            since_q <= 4'hF;
        end else begin
            bv_q <= s_axi_bvalid_out;
            fs_q <= {fs_q[1:0], framer_rx_clock_in};
            since_q <= det ? 4'h0 : (since_q == 4'hF ? since_q : since_q + 4'h1);
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_q <= s_axi_awaddr_in;
                busy_q <= 1'b1;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                busy_q <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                wd_q <= s_axi_wdata_in;
                ws_q <= s_axi_wstrb_in;
            end
            // Apply once when the response first shows
            if (s_axi_bvalid_out && !bv_q && aw_q[7:4] == 4'h0) begin
                if (aw_q[3:2] == 2'd3) begin
                    if (ws_q[0]) esel_q <= wd_q[`BIT_RX_EDGE_SELECT];
                end else begin
                    if (ws_q[0]) cfg_q[aw_q[3:2]][7:0] <= wd_q[7:0];
                    if (ws_q[1]) cfg_q[aw_q[3:2]][11:8] <= wd_q[11:8];
                end
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    property p_reset_inputs;
        $rose(arst_n_in) |-> rx_multi_pin_oe_out == '0 && rx_multi_pin_out == '0;
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("pin driven after reset");
    property p_dir_follows;
        !busy_q |-> rx_multi_pin_oe_out == exp_oe;
    endproperty
    a_dir_follows: assert property (p_dir_follows) else $error("direction mismatch");
    property p_dir_on_write;
        $changed(rx_multi_pin_oe_out) |-> $past(busy_q);
    endproperty
    a_dir_on_write: assert property (p_dir_on_write) else $error("direction moved alone");
    property p_launch_edge;
        $changed(rx_multi_pin_out) |-> since_q <= 4'd4;
    endproperty
    a_launch_edge: assert property (p_launch_edge) else $error("launch off edge");
    property p_fixed_levels;
        since_q == 4'd6 && !busy_q |-> (rx_multi_pin_out & hi_m) == hi_m && (rx_multi_pin_out & lo_m) == 9'h000;
    endproperty
    a_fixed_levels: assert property (p_fixed_levels) else $error("fixed level wrong");
    property p_read_answer;
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
    property p_read_refuse;
        s_axi_rvalid_out |-> !s_axi_arready_out;
    endproperty
    a_read_refuse: assert property (p_read_refuse) else $error("address taken while busy");
endmodule

bind receive_multifunction_port_mux rx_mux_chk chk_u (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .s_axi_awaddr_in(s_axi_awaddr_in),
    .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wdata_in(s_axi_wdata_in), .s_axi_wstrb_in(s_axi_wstrb_in),
    .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rvalid_out(s_axi_rvalid_out), .framer_rx_clock_in(framer_rx_clock_in),
    .rx_multi_pin_out(rx_multi_pin_out), .rx_multi_pin_oe_out(rx_multi_pin_oe_out)
);
`default_nettype wire

/* tb/framer_rx_model.sv */
// Framer receive side: clock inside frames and pin wire levels
`timescale 1ns/100ps
`default_nettype none
module framer_rx_model (
    input  wire logic       run_in,
    input  wire logic [8:0] pattern_in,
    input  wire logic [8:0] dev_pin_in,
    input  wire logic [8:0] dev_oe_in,
    output var  logic       fclk_out,
    output var  logic [8:0] pin_out
);
    // Clock toggles only within a frame, rests low between frames
    initial fclk_out = 1'b0;
    always #40 fclk_out = run_in ? ~fclk_out : 1'b0;
    // Wire level: device when it drives, framer pattern otherwise
    always @* begin
        for (int i = 0; i < 9; i++) begin
            pin_out[i] = dev_oe_in[i] ? dev_pin_in[i] : pattern_in[i];
        end
    end
endmodule
`default_nettype wire

/* tb/tb_receive_multifunction_port_mux.sv */
// Testbench for the receive multifunction pin multiplexer
`timescale 1ns/100ps
`default_nettype none
`include "rx_mux_consts.vh"
module tb_receive_multifunction_port_mux;
    logic        clk_in = 1'b0, arst_n_in = 1'b0, run = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        awready, wready, arready, bvalid, rvalid, fclk;
    logic [1:0]  bresp, rresp;
    logic [8:0]  pat = 9'h000, pin_w, pout, poe;
    int          mismatches = 0, cmp_count = 0;

    receive_multifunction_port_mux dut_u (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(1'b1),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(1'b1), .framer_rx_clock_in(fclk), .rx_multi_pin_in(pin_w),
        .rx_multi_pin_out(pout), .rx_multi_pin_oe_out(poe)
    );
    framer_rx_model framer_u (
        .run_in(run), .pattern_in(pat), .dev_pin_in(pout), .dev_oe_in(poe),
        .fclk_out(fclk), .pin_out(pin_w)
    );

    // Clock
    always #2 clk_in = ~clk_in;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bus write: hold each channel until taken, then wait for response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic aw_hs, w_hs, b_hs;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        b_hs = 1'b0;
        while (!b_hs) begin
            @(negedge clk_in);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid;
            if (b_hs) chk(32'(bresp), 32'(er));
            @(posedge clk_in);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end
    endtask

    // Bus read with expected data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_hs, r_hs;
        araddr <= a;
        arvalid <= 1'b1;
        r_hs = 1'b0;
        while (!r_hs) begin
            @(negedge clk_in);
            ar_hs = arvalid && arready;
            r_hs = rvalid;
            if (r_hs) chk(rdata, ed);
            if (r_hs) chk(32'(rresp), 32'(er));
            @(posedge clk_in);
            if (ar_hs) arvalid <= 1'b0;
        end
    endtask

    // Run the framer clock to its next rising or falling edge
    task automatic fedge(input logic rise);
        run = 1'b1;
        if (rise) @(posedge fclk);
        else @(negedge fclk);
        repeat (8) @(posedge clk_in);
    endtask

    // End a frame with the clock low
    task automatic fstop;
        if (fclk) @(negedge fclk);
        run = 1'b0;
        repeat (12) @(posedge clk_in);
    endtask

    task automatic end_of_test;
        $display("TB: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #40000;
        mismatches++;
        end_of_test;
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk_in);
        arst_n_in <= 1'b1;
        chk(32'(poe), 32'h0000_0000);
        rd(`OFS_PIN_CFG_A, 32'h0000_0000, `RESP_OKAY);
        rd(`OFS_DIG_IF_CTRL3, 32'h0000_0000, `RESP_OKAY);
        rd(8'h3C, 32'h0000_0000, `RESP_SLVERR);
        wr(8'h40, 32'h0000_FFFF, 4'hF, `RESP_SLVERR);
        $display("TB: reset test done");
        wr(`OFS_PIN_CFG_A, 32'h0000_0A98, 4'h3, `RESP_OKAY);
        wr(`OFS_PIN_CFG_B, 32'h0000_0021, 4'h3, `RESP_OKAY);
        wr(`OFS_PIN_CFG_C, 32'h0000_0FFF, 4'h1, `RESP_OKAY);
        repeat (2) @(posedge clk_in);
        chk(32'(poe), 32'h0000_006D);
        rd(`OFS_PIN_CFG_C, 32'h0000_00FF, `RESP_OKAY);
        wr(`OFS_PIN_CFG_C, 32'h0000_0000, 4'h3, `RESP_OKAY);
        repeat (2) @(posedge clk_in);
        chk(32'(poe), 32'h0000_0049);
        $display("TB: direction test done");
        pat <= 9'h1FF;
        wr(`OFS_DIG_IF_CTRL3, 32'h0000_0001, 4'h1, `RESP_OKAY);
        wr(`OFS_OUT_DATA_PUSH, 32'h0000_01FF, 4'h1, `RESP_OKAY);
        rd(`OFS_OUT_DATA_PUSH, 32'h0000_0000, `RESP_OKAY);
        fedge(1'b1);
        chk(32'(pout & 9'h049), 32'h0000_0041);
        rd(`OFS_PIN_STATUS, 32'h0000_0212, `RESP_OKAY);
        fstop;
        wr(`OFS_DIG_IF_CTRL3, 32'h0000_0000, 4'h1, `RESP_OKAY);
        wr(`OFS_OUT_DATA_PUSH, 32'h0000_0000, 4'h1, `RESP_OKAY);
        pat <= 9'h000;
        fedge(1'b1);
        chk(32'(pout & 9'h049), 32'h0000_0041);
        rd(`OFS_PIN_STATUS, 32'h0000_0012, `RESP_OKAY);
        fedge(1'b0);
        chk(32'(pout & 9'h049), 32'h0000_0040);
        rd(`OFS_PIN_STATUS, 32'h0000_0200, `RESP_OKAY);
        fstop;
        $display("TB: edge test done");
        wr(`OFS_PIN_CFG_B, 32'h0000_0011, 4'h3, `RESP_OKAY);
        rd(`OFS_PIN_STATUS, 32'h0000_0A00, `RESP_OKAY);
        wr(`OFS_PIN_CFG_B, 32'h0000_0021, 4'h3, `RESP_OKAY);
        wr(`OFS_PIN_STATUS, 32'h0000_FFFF, 4'hF, `RESP_OKAY);
        rd(`OFS_PIN_STATUS, 32'h0000_0200, `RESP_OKAY);
        $display("TB: duplicate test done");
        for (int i = 0; i < 16; i++) begin
            wr(`OFS_OUT_DATA_PUSH, 32'(i), 4'h1, `RESP_OKAY);
        end
        rd(`OFS_PIN_STATUS, 32'h0000_0400, `RESP_OKAY);
        // Push into a full buffer stalls until the framer drains a word
        fork
            wr(`OFS_OUT_DATA_PUSH, 32'h0000_0010, 4'h1, `RESP_OKAY);
            for (int k = 0; k < 17; k++) begin
                fedge(1'b0);
                chk(32'(pout[0]), 32'(k % 2));
            end
        join
        fstop;
        rd(`OFS_PIN_STATUS, 32'h0000_0200, `RESP_OKAY);
        $display("TB: buffer test done");
        end_of_test;
    end
endmodule
`default_nettype wire
